// ---- bench/tb.sv ----
// Self-checking bench for the user data bit manager.
// Assumes udm_host drives the register port; the bench drives the bit streams.
`timescale 1ns/1ns
`default_nettype none
module tb
  import udm_pkg::*;
;
  logic       ref_clk;
  logic       arst_n;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_q;
  logic       reg_wr;
  logic       reg_rd;
  logic       rx_u_stb;
  logic       rx_u_bit;
  logic       rx_blk_start;
  logic       tx_u_req;
  logic       tx_blk_start;
  logic       tx_u_bit_q;
  logic       irq_q;
  logic [7:0] d;
  logic [7:0] e;
  logic [63:0] g;
  int         num_errors;
  int         tests_run;

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  udm_host i_host (.ref_clk(ref_clk), .reg_rdata_q(reg_rdata_q), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  udm_top i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .rx_u_stb(rx_u_stb), .rx_u_bit(rx_u_bit), .rx_blk_start(rx_blk_start),
    .tx_u_req(tx_u_req), .tx_blk_start(tx_blk_start), .tx_u_bit_q(tx_u_bit_q),
    .irq_q(irq_q));

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_of_test;
    $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic rxb(input logic b, input logic s);
    @(posedge ref_clk);
    rx_u_stb     <= 1'b1;
    rx_u_bit     <= b;
    rx_blk_start <= s;
    @(posedge ref_clk);
    rx_u_stb     <= 1'b0;
    rx_u_bit     <= ~b;
    rx_blk_start <= 1'b0;
  endtask : rxb

  task automatic txb(input logic s, output logic b);
    @(posedge ref_clk);
    tx_u_req     <= 1'b1;
    tx_blk_start <= s;
    @(posedge ref_clk);
    tx_u_req     <= 1'b0;
    tx_blk_start <= 1'b0;
    #1;
    b = tx_u_bit_q;
  endtask : txb

  // Collects n transmitted bits, earliest in the highest used position.
  task automatic tx_bits(input logic s, input int n, output logic [63:0] got);
    logic b;
    got = '0;
    for (int i = 0; i < n; i++)
    begin
      txb(s && i == 0, b);
      got = {got[62:0], b};
    end
  endtask : tx_bits

  // Sends n units cycling through three, then a trailing gap of ten zeros.
  task automatic msg(input logic [23:0] ius, input int n, input int fill);
    for (int k = 0; k < n; k++)
    begin
      for (int j = 0; j < 8; j++)
        rxb(ius[23 - 8 * (k % 3) - j], 1'b0);
      if (k < n - 1)
        repeat (fill) rxb(1'b0, 1'b0);
    end
    repeat (10) rxb(1'b0, 1'b0);
  endtask : msg

  // Skips the leading gap, then expects three units split by fill zeros and a gap.
  task automatic tx_check(input logic [23:0] ius, input int fill, input string nm);
    logic [63:0] got;
    logic [63:0] exp;
    logic        b;
    got = '0;
    exp = '0;
    b   = 1'b0;
    for (int i = 0; i < 30 && b !== 1'b1; i++)
      txb(1'b0, b);
    got[0] = b;
    for (int i = 1; i < 34 + 2 * fill; i++)
    begin
      txb(1'b0, b);
      got = {got[62:0], b};
    end
    for (int i = 0; i < 3; i++)
    begin
      exp = (exp << 8) | 64'(ius[23 - 8 * i -: 8]);
      if (i < 2)
        exp = exp << fill;
    end
    chk(nm, exp << 10, got);
  endtask : tx_check

  task automatic t_reset;
    logic [1:0] modes [3] = '{UDM_MODE_ZERO, UDM_MODE_BLK, UDM_MODE_IEC};
    i_host.rd(UDM_CTRL, d);
    chk("ctrl", 8'h00, d);
    i_host.rd(UDM_STAT, d);
    chk("stat", 8'h00, d);
    i_host.rd(UDM_MASK, d);
    chk("mask", 8'h00, d);
    i_host.rd(UDM_OFL, d);
    chk("filler", 8'h08, d);
    i_host.wr(7'h7f, 8'hff);
    i_host.rd(7'h7f, d);
    chk("unmapped", 8'h00, d);
    foreach (modes[i])
    begin
      i_host.set_mode(modes[i]);
      i_host.rd(UDM_CTRL, d);
      chk("mode", {6'h00, modes[i]}, d);
    end
    i_host.set_mode(UDM_MODE_ZERO);
  endtask : t_reset

  task automatic t_cs;
    i_host.cs_wr(23, 8'ha1, 8'hb2);
    i_host.cs_wr(0, 8'h5c, 8'hc5);
    i_host.cs_rd(23, d, e);
    chk("cs23", 16'ha1b2, {d, e});
    i_host.cs_rd(0, d, e);
    chk("cs0", 16'h5cc5, {d, e});
  endtask : t_cs

  task automatic t_fifo;
    i_host.set_mode(UDM_MODE_IEC);
    repeat (12) rxb(1'b0, 1'b0);
    msg(24'hc080c1, 3, 2);
    i_host.rd(UDM_OFL, d);
    chk("filler", 8'h02, d);
    i_host.rd(UDM_QSUB_LO, d);
    chk("qsub", 8'h05, d & 8'h07);
    tx_check(24'hc080c1, 2, "fifo_tx");
  endtask : t_fifo

  task automatic t_ovf;
    msg(24'h808080, 70, 0);
    i_host.rd(UDM_STAT, d);
    chk("stat", 8'h01, d & 8'h01);
    chk("irq_masked", 1'b0, irq_q);
    i_host.wr(UDM_MASK, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("irq", 1'b1, irq_q);
    tx_bits(1'b0, 20, g);
    chk("tx_cleared", 64'h0, g);
    i_host.wr(UDM_STAT, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("irq_clr", 1'b0, irq_q);
    msg(24'hc181c0, 3, 3);
    i_host.rd(UDM_OFL, d);
    chk("filler_min", 8'h00, d);
    tx_check(24'hc181c0, 0, "resume_tx");
  endtask : t_ovf

  task automatic t_blk;
    logic [7:0] v;
    i_host.set_mode(UDM_MODE_BLK);
    i_host.wr(UDM_UBUF_BASE, 8'ha5);
    i_host.wr(UDM_UBUF_BASE + 7'h01, 8'h5a);
    i_host.rd(UDM_UBUF_BASE, d);
    chk("ubuf", 8'ha5, d);
    tx_bits(1'b1, 16, g);
    chk("blk_tx", 16'ha55a, g);
    for (int i = 0; i < 384; i++)
    begin
      v = 8'(i / 8 * 5 + 3);
      rxb(v[7 - i % 8], i == 0);
    end
    repeat (3) @(posedge ref_clk);
    i_host.rd(UDM_UBUF_BASE, d);
    chk("blk_rx0", 8'h03, d);
    i_host.rd(UDM_UBUF_LAST, d);
    chk("blk_rx47", 8'hee, d);
    i_host.set_mode(UDM_MODE_ZERO);
    tx_bits(1'b1, 16, g);
    chk("zero_tx", 64'h0, g);
  endtask : t_blk

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    $display("Error watchdog expected finish seen timeout");
    end_of_test();
  end

  initial
  begin
    num_errors   = 0;
    tests_run    = 0;
    arst_n       = 1'b0;
    rx_u_stb     = 1'b0;
    rx_u_bit     = 1'b0;
    rx_blk_start = 1'b0;
    tx_u_req     = 1'b0;
    tx_blk_start = 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("rst_outputs", 10'h000, {reg_rdata_q, tx_u_bit_q, irq_q});
    arst_n <= 1'b1;
    t_reset();
    t_cs();
    t_fifo();
    t_ovf();
    t_blk();
    end_of_test();
  end
endmodule : tb
`default_nettype wire

// ---- bench/udm_host.sv ----
// Host controller model for the register port of the user data bit manager.
// Assumes ref_clk from the bench; read data stand from the cycle after the strobe until the next read.
`timescale 1ns/1ns
`default_nettype none
module udm_host
  import udm_pkg::*;
(
  input  wire logic       ref_clk,     // Clock.
  input  wire logic [7:0] reg_rdata_q, // Read data.
  output logic      [6:0] reg_addr,    // Address.
  output logic      [7:0] reg_wdata,   // Write data.
  output logic            reg_wr,      // Write strobe.
  output logic            reg_rd       // Read strobe.
);
  initial
  begin
    reg_addr  = 7'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // Released lines carry the inverse of their last value, so a design that
  // samples them late sees garbage instead of a lucky match.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata_q;
  endtask : rd
  task automatic cs_wr(input int w, input logic [7:0] a, input logic [7:0] b);
    wr(UDM_CS_BASE + 7'(2 * w), a);
    wr(UDM_CS_BASE + 7'(2 * w + 1), b);
  endtask : cs_wr
  task automatic cs_rd(input int w, output logic [7:0] a, output logic [7:0] b);
    rd(UDM_CS_BASE + 7'(2 * w), a);
    rd(UDM_CS_BASE + 7'(2 * w + 1), b);
  endtask : cs_rd
  // The withdrawn mode is never selected; the message FIFO mode replaces it.
  task automatic set_mode(input logic [1:0] m);
    wr(UDM_CTRL, {6'h00, (m === UDM_MODE_RSVD) ? UDM_MODE_IEC : m});
  endtask : set_mode
endmodule : udm_host
`default_nettype wire

// ---- design/udm_fifo.sv ----
// Show-ahead FIFO of information units and end-of-message markers.
// Assumes the writer never writes while full; clr empties it at once.
`timescale 1ns/1ns
`default_nettype none
module udm_fifo
  import udm_pkg::*;
(
  input  wire logic       ref_clk,  // Clock.
  input  wire logic       arst_n,   // Asynchronous reset, active low.
  input  wire logic       clr,      // Synchronous clear.
  input  wire logic       wr_en,    // Push.
  input  wire logic [8:0] wr_data,  // Bit 8 marks end of message.
  input  wire logic       rd_en,    // Pop.
  output logic      [8:0] rd_data,  // Head entry.
  output logic            full,     // No room.
  output logic            empty     // Nothing stored.
);
  logic [8:0]             mem [UDM_FIFO_DEPTH];
  logic [UDM_FIFO_AW-1:0] wp_q;
  logic [UDM_FIFO_AW-1:0] rp_q;
  logic [UDM_FIFO_AW:0]   cnt_q;

  assign full    = (cnt_q == (UDM_FIFO_AW+1)'(UDM_FIFO_DEPTH));
  assign empty   = (cnt_q == '0);
  assign rd_data = mem[rp_q];

  always_ff @(posedge ref_clk)
  begin
    if (wr_en && !full)
    begin
      mem[wp_q] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else if (clr)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (wr_en && !full)
      begin
        wp_q <= wp_q + UDM_FIFO_AW'(1);
      end
      if (rd_en && !empty)
      begin
        rp_q <= rp_q + UDM_FIFO_AW'(1);
      end
      cnt_q <= cnt_q + (UDM_FIFO_AW+1)'(wr_en && !full) - (UDM_FIFO_AW+1)'(rd_en && !empty);
    end
  end
endmodule : udm_fifo
`default_nettype wire

// ---- design/udm_pkg.sv ----
// Constants, register map and types for the user data bit manager.
// Assumes an 8-bit register port with a 7-bit byte address.
package udm_pkg;
  localparam int          UDM_CS_WORDS  = 24;
  localparam int          UDM_U_BYTES   = 48;
  localparam logic [8:0]  UDM_U_LAST    = 9'h17f;
  localparam logic [6:0]  UDM_CS_BASE   = 7'h00;
  localparam logic [6:0]  UDM_CS_LAST   = 7'h2f;
  localparam logic [6:0]  UDM_CTRL      = 7'h30;
  localparam logic [6:0]  UDM_STAT      = 7'h31;
  localparam logic [6:0]  UDM_MASK      = 7'h32;
  localparam logic [6:0]  UDM_OFL       = 7'h33;
  localparam logic [6:0]  UDM_QSUB_HI   = 7'h34;
  localparam logic [6:0]  UDM_QSUB_LO   = 7'h35;
  localparam logic [6:0]  UDM_UBUF_BASE = 7'h40;
  localparam logic [6:0]  UDM_UBUF_LAST = 7'h6f;
  localparam logic [1:0]  UDM_MODE_ZERO = 2'h0;
  localparam logic [1:0]  UDM_MODE_BLK  = 2'h1;
  localparam logic [1:0]  UDM_MODE_RSVD = 2'h2;
  localparam logic [1:0]  UDM_MODE_IEC  = 2'h3;
  localparam logic [1:0]  UDM_CTRL_RST  = 2'h0;
  localparam logic [2:0]  UDM_IU_LASTB  = 3'h7;
  localparam logic [3:0]  UDM_GAP_ZEROS = 4'h9;
  localparam logic [3:0]  UDM_MAX_FILL  = 4'h8;
  localparam int          UDM_FIFO_DEPTH = 64;
  localparam int          UDM_FIFO_AW   = 6;
  typedef enum logic [1:0] {UDM_TX_WAIT, UDM_TX_IU, UDM_TX_FILL} udm_tx_st_t;
endpackage : udm_pkg

// ---- design/udm_top.sv ----
// User data bit manager: zero, block and consumer-message FIFO modes, plus
// the two-byte channel status word buffer, all behind an 8-bit register port.
// Assumes rx and tx bit strobes come from logic on ref_clk.
// Functional notes
// - Channel status buffer: 24 words, A high
// - Status read returns A byte, then B
// - Four user modes: zero, block, reserved, FIFO
// - Zero mode sends only zero user bits
// - Block mode: three buffers, middle host visible
// - Only block mode merges host user bits
// - User buffer access one byte per address
// - Byte MSB is earliest bit; first byte first
// - Unit is 1 start bit plus 7
// - 0-8 zeros join units; nine split messages
// - Second-position bits collected for host reading
// - Whole message stored before transmission starts
// - Only units and end-of-message markers enter FIFO; filler discarded
// - Output filler equals shortest observed input filler
// - Empty FIFO sends zeros until full message
// - Overwrite synchronously clears the whole FIFO
// - Maskable interrupt on FIFO overwrite reset
`timescale 1ns/1ns
`default_nettype none
module udm_top
  import udm_pkg::*;
(
  input  wire logic       ref_clk,      // 10 MHz clock.
  input  wire logic       arst_n,       // Asynchronous reset, active low.
  input  wire logic [6:0] reg_addr,     // Register byte address.
  input  wire logic [7:0] reg_wdata,    // Write data.
  input  wire logic       reg_wr,       // Write strobe.
  input  wire logic       reg_rd,       // Read strobe.
  output logic      [7:0] reg_rdata_q,  // Read data, cycle after strobe.
  input  wire logic       rx_u_stb,     // Received user bit valid.
  input  wire logic       rx_u_bit,     // Received user bit.
  input  wire logic       rx_blk_start, // Received bit is first of block.
  input  wire logic       tx_u_req,     // Transmitter takes a user bit.
  input  wire logic       tx_blk_start, // Requested bit is first of block.
  output logic            tx_u_bit_q,   // User bit for the transmitter.
  output logic            irq_q         // Overwrite interrupt, active high.
);
  logic [15:0]    cs_q [UDM_CS_WORDS];
  logic [1:0]     mode_q;
  logic           stat_q;
  logic           mask_q;
  logic [383:0]   d_q;
  logic [383:0]   e_q;
  logic [383:0]   f_q;
  logic [8:0]     rx_idx_q;
  logic [8:0]     tx_idx_q;
  logic [8:0]     rx_pos;
  logic [8:0]     tx_pos;
  logic           d_full_q;
  logic           rx_in_iu_q;
  logic [2:0]     rx_bc_q;
  logic [7:0]     rx_sh_q;
  logic [3:0]     rx_zc_q;
  logic           rx_seen_q;
  logic           discard_q;
  logic [3:0]     min_fill_q;
  logic [15:0]    qsub_q;
  logic [7:0]     msg_cnt_q;
  logic           iec;
  logic           iu_done;
  logic           gap_hit;
  logic           wr_req;
  logic           ovf;
  logic [8:0]     fifo_wd;
  logic [8:0]     head;
  logic           fifo_full;
  logic           fifo_empty;
  logic           tx_pop;
  logic           tx_iec_bit;
  udm_tx_st_t     tx_st_q;
  logic [6:0]     tx_sh_q;
  logic [2:0]     tx_bc_q;
  logic [3:0]     tx_fc_q;
  logic [3:0]     tx_gap_q;

  // Top bit index of a user buffer byte; byte 0 holds the earliest bits.
  function automatic logic [8:0] ubuf_top(input logic [6:0] a);
    logic [6:0] k;
    k = a - UDM_UBUF_BASE;
    ubuf_top = UDM_U_LAST - {k[5:0], 3'b000};
  endfunction : ubuf_top

  function automatic logic in_ubuf(input logic [6:0] a);
    in_ubuf = (a >= UDM_UBUF_BASE) && (a <= UDM_UBUF_LAST);
  endfunction : in_ubuf

  assign iec = (mode_q == UDM_MODE_IEC);

  // Control, status and mask registers.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_q <= UDM_CTRL_RST;
      mask_q <= 1'b0;
      stat_q <= 1'b0;
      irq_q  <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == UDM_CTRL)
      begin
        mode_q <= reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == UDM_MASK)
      begin
        mask_q <= reg_wdata[0];
      end
      // A new overwrite event wins over a clear in the same cycle.
      if (ovf)
      begin
        stat_q <= 1'b1;
      end
      else if (reg_wr && reg_addr == UDM_STAT && reg_wdata[0])
      begin
        stat_q <= 1'b0;
      end
      irq_q <= stat_q & mask_q;
    end
  end

  // Channel status access buffer: even address A byte, odd address B byte.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < UDM_CS_WORDS; i++)
      begin
        cs_q[i] <= '0;
      end
    end
    else if (reg_wr && reg_addr <= UDM_CS_LAST)
    begin
      if (!reg_addr[0])
      begin
        cs_q[reg_addr[5:1]][15:8] <= reg_wdata;
      end
      else
      begin
        cs_q[reg_addr[5:1]][7:0] <= reg_wdata;
      end
    end
  end

  // Read port.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata_q <= '0;
    end
    else if (reg_rd)
    begin
      if (reg_addr <= UDM_CS_LAST)
      begin
        reg_rdata_q <= reg_addr[0] ? cs_q[reg_addr[5:1]][7:0]
                                   : cs_q[reg_addr[5:1]][15:8];
      end
      else if (in_ubuf(reg_addr))
      begin
        reg_rdata_q <= e_q[ubuf_top(reg_addr) -: 8];
      end
      else
      begin
        case (reg_addr)
          UDM_CTRL:    reg_rdata_q <= {6'h00, mode_q};
          UDM_STAT:    reg_rdata_q <= {7'h00, stat_q};
          UDM_MASK:    reg_rdata_q <= {7'h00, mask_q};
          UDM_OFL:     reg_rdata_q <= {4'h0, min_fill_q};
          UDM_QSUB_HI: reg_rdata_q <= qsub_q[15:8];
          UDM_QSUB_LO: reg_rdata_q <= qsub_q[7:0];
          default:     reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // Block mode: D fills from the receiver, E is host visible, F feeds out.
  assign rx_pos = rx_blk_start ? 9'h000 : rx_idx_q;
  assign tx_pos = tx_blk_start ? 9'h000 : tx_idx_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      d_q      <= '0;
      e_q      <= '0;
      f_q      <= '0;
      rx_idx_q <= '0;
      tx_idx_q <= '0;
      d_full_q <= 1'b0;
    end
    else
    begin
      d_full_q <= 1'b0;
      if (rx_u_stb)
      begin
        d_q[UDM_U_LAST - rx_pos] <= rx_u_bit;
        rx_idx_q <= (rx_pos == UDM_U_LAST) ? 9'h000 : rx_pos + 9'h001;
        d_full_q <= (rx_pos == UDM_U_LAST) && (mode_q == UDM_MODE_BLK);
      end
      if (d_full_q)
      begin
        e_q <= d_q;
      end
      if (reg_wr && in_ubuf(reg_addr))
      begin
        e_q[ubuf_top(reg_addr) -: 8] <= reg_wdata;
      end
      if (tx_u_req)
      begin
        tx_idx_q <= (tx_pos == UDM_U_LAST) ? 9'h000 : tx_pos + 9'h001;
        if (tx_pos == 9'h000)
        begin
          f_q <= e_q;
        end
      end
    end
  end

  // Consumer-format receive parser.
  assign iu_done = rx_u_stb && rx_in_iu_q && (rx_bc_q == UDM_IU_LASTB);
  assign gap_hit = rx_u_stb && !rx_in_iu_q && !rx_u_bit && rx_seen_q
                   && (rx_zc_q == UDM_MAX_FILL);
  assign wr_req  = iec && !discard_q && (iu_done || gap_hit);
  assign ovf     = wr_req && fifo_full;
  assign fifo_wd = gap_hit ? 9'h100 : {1'b0, rx_sh_q[6:0], rx_u_bit};

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_in_iu_q <= 1'b0;
      rx_bc_q    <= '0;
      rx_sh_q    <= '0;
      rx_zc_q    <= UDM_GAP_ZEROS;
      rx_seen_q  <= 1'b0;
      discard_q  <= 1'b0;
      min_fill_q <= UDM_MAX_FILL;
      qsub_q     <= '0;
    end
    else
    begin
      if (ovf)
      begin
        discard_q <= 1'b1;
      end
      if (rx_u_stb && rx_in_iu_q)
      begin
        rx_sh_q <= {rx_sh_q[6:0], rx_u_bit};
        rx_bc_q <= rx_bc_q + 3'h1;
        if (iu_done)
        begin
          rx_in_iu_q <= 1'b0;
          rx_zc_q    <= '0;
          qsub_q     <= {qsub_q[14:0], rx_sh_q[5]};
        end
      end
      else if (rx_u_stb && rx_u_bit)
      begin
        rx_in_iu_q <= 1'b1;
        rx_sh_q    <= 8'h01;
        rx_bc_q    <= 3'h1;
        rx_seen_q  <= 1'b1;
        if (rx_zc_q >= UDM_GAP_ZEROS)
        begin
          discard_q <= 1'b0;
        end
        else if (rx_seen_q && rx_zc_q < min_fill_q)
        begin
          min_fill_q <= rx_zc_q;
        end
      end
      else if (rx_u_stb)
      begin
        if (rx_zc_q < UDM_GAP_ZEROS)
        begin
          rx_zc_q <= rx_zc_q + 4'h1;
        end
        if (gap_hit)
        begin
          rx_seen_q <= 1'b0;
        end
      end
    end
  end

  udm_fifo u_fifo (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clr     (ovf),
    .wr_en   (wr_req && !fifo_full),
    .wr_data (fifo_wd),
    .rd_en   (tx_pop),
    .rd_data (head),
    .full    (fifo_full),
    .empty   (fifo_empty)
  );

  // Count of complete messages held; transmission waits for one.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      msg_cnt_q <= '0;
    end
    else if (ovf)
    begin
      msg_cnt_q <= '0;
    end
    else
    begin
      msg_cnt_q <= msg_cnt_q + 8'(wr_req && gap_hit)
                   - 8'(tx_pop && head[8]);
    end
  end

  // Consumer-format transmit sequencer.
  always_comb
  begin
    tx_pop     = 1'b0;
    tx_iec_bit = 1'b0;
    if (tx_u_req && iec && !ovf)
    begin
      case (tx_st_q)
        UDM_TX_WAIT:
        begin
          tx_pop = !fifo_empty && msg_cnt_q != '0
                   && tx_gap_q >= UDM_GAP_ZEROS;
          tx_iec_bit = tx_pop && head[7];
        end
        UDM_TX_IU:
        begin
          tx_iec_bit = tx_sh_q[6];
        end
        UDM_TX_FILL:
        begin
          tx_pop = !fifo_empty && (head[8] || tx_fc_q >= min_fill_q);
          tx_iec_bit = tx_pop && !head[8] && head[7];
        end
        default:
        begin
          tx_pop = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_st_q  <= UDM_TX_WAIT;
      tx_sh_q  <= '0;
      tx_bc_q  <= '0;
      tx_fc_q  <= '0;
      tx_gap_q <= UDM_GAP_ZEROS;
    end
    else if (ovf)
    begin
      // A message cut short by the clear is closed by a fresh full gap.
      tx_st_q  <= UDM_TX_WAIT;
      tx_gap_q <= '0;
    end
    else if (tx_u_req && iec)
    begin
      if (tx_pop && !head[8])
      begin
        tx_st_q <= UDM_TX_IU;
        tx_sh_q <= head[6:0];
        tx_bc_q <= '0;
      end
      else
      begin
        case (tx_st_q)
          UDM_TX_WAIT:
          begin
            if (tx_gap_q < UDM_GAP_ZEROS)
            begin
              tx_gap_q <= tx_gap_q + 4'h1;
            end
          end
          UDM_TX_IU:
          begin
            tx_sh_q <= {tx_sh_q[5:0], 1'b0};
            tx_bc_q <= tx_bc_q + 3'h1;
            if (tx_bc_q == 3'h6)
            begin
              tx_st_q <= UDM_TX_FILL;
              tx_fc_q <= '0;
            end
          end
          UDM_TX_FILL:
          begin
            if (tx_pop)
            begin
              tx_st_q  <= UDM_TX_WAIT;
              tx_gap_q <= 4'h1;
            end
            else
            begin
              tx_fc_q <= tx_fc_q + 4'h1;
            end
          end
          default:
          begin
            tx_st_q <= UDM_TX_WAIT;
          end
        endcase
      end
    end
  end

  // Output bit selection by mode; the reserved mode sends zeros.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_u_bit_q <= 1'b0;
    end
    else if (tx_u_req)
    begin
      case (mode_q)
        UDM_MODE_BLK: tx_u_bit_q <= (tx_pos == 9'h000) ? e_q[UDM_U_LAST]
                                    : f_q[UDM_U_LAST - tx_pos];
        UDM_MODE_IEC: tx_u_bit_q <= tx_iec_bit;
        default:      tx_u_bit_q <= 1'b0;
      endcase
    end
  end

  AST_ZERO_MODE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tx_u_req && mode_q == UDM_MODE_ZERO |=> !tx_u_bit_q)
    else $error("zero mode sent a one");
  AST_RSVD_MODE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tx_u_req && mode_q == UDM_MODE_RSVD |=> !tx_u_bit_q)
    else $error("reserved mode sent a one");
  AST_OVF_CLEAR: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ovf |=> fifo_empty && msg_cnt_q == '0)
    else $error("fifo not cleared after overwrite");
  // The mask in force one cycle after the event decides whether the line rises.
  AST_OVF_IRQ: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ovf |=> stat_q ##1 irq_q == $past(mask_q))
    else $error("overwrite interrupt does not follow the mask");
  AST_EMPTY_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tx_u_req && iec && tx_st_q == UDM_TX_WAIT && msg_cnt_q == '0 |=> !tx_u_bit_q)
    else $error("bit sent without a whole message");
  AST_START_BIT: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tx_pop && !head[8] |=> tx_u_bit_q ##0 tx_st_q == UDM_TX_IU)
    else $error("unit did not open with a one");
  AST_FILL_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tx_u_req && iec && !ovf && tx_st_q == UDM_TX_FILL && tx_fc_q < min_fill_q && !head[8]
    |=> !tx_u_bit_q)
    else $error("filler shorter than shortest input filler");
  AST_DISCARD: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ovf |=> discard_q && msg_cnt_q == '0 && !wr_req)
    else $error("writes resumed inside a dropped message");
  AST_CS_A_FIRST: assert property (@(posedge ref_clk) disable iff (!arst_n)
    reg_rd && reg_addr == UDM_CS_BASE && !reg_wr |=> reg_rdata_q == $past(cs_q[0][15:8]))
    else $error("channel A byte not returned first");
endmodule : udm_top
`default_nettype wire
